//--- pkg/rx_wakeup_pkg.sv
// Types shared by the receiver wake block.
package rx_wakeup_pkg;

  typedef enum logic [2:0] {
    SEQ_OFF      = 3'b000,
    SEQ_ARMED    = 3'b001,
    CALIBRATION_INTERVAL      = 3'b010,
    SEQ_SETTLE   = 3'b011,
    SEQ_CS_CHECK = 3'b100,
    SEQ_RX_ON    = 3'b101
  } seq_state_t;

  typedef logic [7:0] offset_t;

endpackage

//--- pkg/rx_wakeup_regs.svh
// Register offsets, field positions, reset values and timing constants for the receiver wake block.
`ifndef RX_WAKEUP_REGS_SVH
`define RX_WAKEUP_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MAIN          8'h00
`define OFS_SEQUENCING    8'h04
`define OFS_INTERFACE     8'h08
`define OFS_GAIN_THREE    8'h0C
`define OFS_GAIN_FOUR     8'h10
`define OFS_PIN_SELECT    8'h14
`define OFS_STATUS        8'h18
`define OFS_AVG_FREQUENCY_WORD      8'h1C
`define OFS_INST_FREQUENCY_WORD     8'h20
`define OFS_SAMPLE_DIV    8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MAIN_PDMODE_HI    1
`define MAIN_PDMODE_LO    0
`define MAIN_SEQPD_BIT    2
`define MAIN_CAL_HI       5
`define MAIN_CAL_LO       4
`define WAKE_SOURCE_SELECT_BIT      0
`define SEQ_RXW_HI        3
`define SEQ_RXW_LO        1
`define SEQ_CSW_HI        7
`define SEQ_CSW_LO        4
`define IF_SEPDATA_BIT    0
`define IF_OOK_BIT        1
`define GAIN_FIELD_HI     4
`define CS_SETMODE_BIT    5
`define STAT_CARRIER_BIT  3
`define STAT_RXON_BIT     0
`define STAT_CAL_BIT      1
`define STAT_AFCOK_BIT    2
`define STAT_PD_BIT       4

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define PDMODE_SEQ        2'h3
`define PINSEL_CARRIER    4'h4
`define PINSEL_SAMPLECLK  4'hD
`define CAL_EVERY         2'h0
`define CAL_EVERY16       2'h1
`define CAL_EVERY256      2'h2
`define CS_MARGIN         8'h08
`define SAMPLE_PER_BAUD   8
`define SAMPLE_DIV_RST    16'h0064
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// Timing: one settle or carrier wait step, in ns, at a 10 ns clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define RX_STEP_NS        1000
`define CS_STEP_NS        1000
`define RX_STEP_CYC       (`RX_STEP_NS / `CLK_PERIOD_NS)
`define CS_STEP_CYC       (`CS_STEP_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/rx_wakeup_carrier_sense.sv
// Carrier sense, wake-up sequencer and frequency offset readback with an AXI4-Lite slave.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rx_wakeup_regs.svh"
// What this block does
// - Carrier detect comes from comparing signal strength with a programmable threshold.
// - Threshold set by 5-bit level field together with 5-bit maximum gain field.
// - Carrier detect is readable as a flag in the status register.
// - Pin source select 0100 puts carrier detect on the status pin.
// - Power-down mode field value 11 selects automatic power-up sequencing.
// - In sequencing mode the main register bits control the sequencer.
// - Writing 1 to sequenced power-down bit enters power-down awaiting wake-up.
// - Wake source bit 1: falling edge on select pin starts the sequence.
// - Wake source bit 0 with separate data pins: falling data pin edge starts it.
// - Settle wait (3 bits) and carrier wait (4 bits) fields set sequencer delays.
// - After wake-up, power receiver, check carrier, return to power-down if none.
// - Calibration runs every sequence, every 16th, every 256th, or never.
// - Average offset is signed 8-bit, offset equals value times baud over 16.
// - Average offset is valid for two-level and Gaussian keying, not on-off keying.
// - Instantaneous offset is signed 8-bit, deviation equals value times baud over 8.
// - Instantaneous offset updates per sample clock; select 1101 shows that clock.
// - Demodulator sample clock runs at eight times the baud rate.
// - Demodulated data is filtered digitally, cut-off 0.6 times baud rate; the filter here corners near 0.17 baud.
// - Carrier asserted when strength exceeds level plus 8 while carrier-set mode is 0.
// - Carrier detect flag sits at status bit 3.
module rx_wakeup_carrier_sense #(
  parameter int RX_STEP_CYC = `RX_STEP_CYC,
  parameter int CS_STEP_CYC = `CS_STEP_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clk_en,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [7:0]           rssi_value,
  input  wire logic [7:0]           demod_frequency_word,
  input  wire logic                 cal_done,
  input  wire logic                 wake_select_pin,
  input  wire logic                 data_io_pin_i,
  output logic                      data_io_pin_o,
  output logic                      data_io_pin_oe,
  output logic                      status_pin,
  output logic                      rx_enable,
  output logic                      cal_start,
  output logic                      powered_down,
  output logic [4:0]                max_gain
);
  import rx_wakeup_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]  main_r;
  logic [7:0]  seq_cfg_r;
  logic [1:0]  intf_r;
  logic [4:0]  gain_three_r;
  logic [5:0]  gain_four_r;
  logic [3:0]  pin_sel_r;
  logic [15:0] sample_div_r;
  logic        carrier_r;
  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [15:0] wait_cnt_r;
  logic [7:0]  step_cnt_r;
  logic [7:0]  seq_count_r;
  logic [15:0] div_cnt_r;
  logic        sample_tick_r;
  logic        sample_clk_r;
  logic [7:0]  inst_r;
  logic [11:0] avg_acc_r;
  logic [7:0]  avg_r;
  logic [2:0]  psel_sync_r;
  logic [2:0]  dio_sync_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane0_r;
  logic        seqpd_cmd;
  logic        wake_edge;
  logic        seq_mode;
  logic        do_cal;
  logic        wr_fire;
  logic        rd_fire;

  // Decoding shared by the write path and the read path.
  function automatic logic addr_mapped(input offset_t a);
    case (a)
      `OFS_MAIN, `OFS_SEQUENCING, `OFS_INTERFACE, `OFS_GAIN_THREE, `OFS_GAIN_FOUR,
      `OFS_PIN_SELECT, `OFS_STATUS, `OFS_AVG_FREQUENCY_WORD, `OFS_INST_FREQUENCY_WORD, `OFS_SAMPLE_DIV:
        addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  assign seq_mode = (main_r[`MAIN_PDMODE_HI:`MAIN_PDMODE_LO] == `PDMODE_SEQ);
  assign wr_fire  = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are latched independently, so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register bits; a write without it stores nothing.
  assign seqpd_cmd = wr_fire && w_lane0_r && (aw_addr_r == `OFS_MAIN) && seq_mode
                     && w_data_r[`MAIN_SEQPD_BIT];

  // Software-written configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_r       <= 8'h00;
      seq_cfg_r    <= 8'h00;
      intf_r       <= 2'h0;
      gain_three_r <= 5'h00;
      gain_four_r  <= 6'h00;
      pin_sel_r    <= 4'h0;
      sample_div_r <= `SAMPLE_DIV_RST;
    end else if (clk_en && wr_fire && w_lane0_r) begin
      case (aw_addr_r)
        `OFS_MAIN:       main_r       <= w_data_r;
        `OFS_SEQUENCING: seq_cfg_r    <= w_data_r;
        `OFS_INTERFACE:  intf_r       <= w_data_r[1:0];
        `OFS_GAIN_THREE: gain_three_r <= w_data_r[`GAIN_FIELD_HI:0];
        `OFS_GAIN_FOUR:  gain_four_r  <= w_data_r[5:0];
        `OFS_PIN_SELECT: pin_sel_r    <= w_data_r[3:0];
        `OFS_SAMPLE_DIV: sample_div_r <= {8'h00, w_data_r};
        default:         main_r       <= main_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Reads return one cycle after the address is taken; unmapped words give SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `OFS_MAIN:       s_axi_rdata <= {24'h000000, main_r};
          `OFS_SEQUENCING: s_axi_rdata <= {24'h000000, seq_cfg_r};
          `OFS_INTERFACE:  s_axi_rdata <= {30'h00000000, intf_r};
          `OFS_GAIN_THREE: s_axi_rdata <= {27'h0000000, gain_three_r};
          `OFS_GAIN_FOUR:  s_axi_rdata <= {26'h0000000, gain_four_r};
          `OFS_PIN_SELECT: s_axi_rdata <= {28'h0000000, pin_sel_r};
          `OFS_STATUS:     s_axi_rdata <= {27'h0000000, powered_down, carrier_r,
                                           !intf_r[`IF_OOK_BIT], cal_start ||
                                           (state_r == CALIBRATION_INTERVAL), rx_enable};
          `OFS_AVG_FREQUENCY_WORD:   s_axi_rdata <= {24'h000000, avg_r};
          `OFS_INST_FREQUENCY_WORD:  s_axi_rdata <= {24'h000000, inst_r};
          `OFS_SAMPLE_DIV: s_axi_rdata <= {16'h0000, sample_div_r};
          default:         s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier sense
  // ----------------------------------------------------------------
  // Signal strength is taken at the programmed maximum gain, so the level
  // field only holds an absolute threshold for one gain setting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_r <= 1'b0;
    end else if (clk_en) begin
      carrier_r <= !gain_four_r[`CS_SETMODE_BIT] &&
                   (rssi_value > ({3'h0, gain_four_r[4:0]} + `CS_MARGIN));
    end
  end

  // ----------------------------------------------------------------
  // Wake pin synchronisers and falling edge detect
  // ----------------------------------------------------------------
  // The first stage feeds only the second; the edge is seen between stages two and three.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psel_sync_r <= 3'h7;
      dio_sync_r  <= 3'h7;
    end else if (clk_en) begin
      psel_sync_r <= {psel_sync_r[1:0], wake_select_pin};
      dio_sync_r  <= {dio_sync_r[1:0], data_io_pin_i};
    end
  end

  always_comb begin
    if (seq_cfg_r[`WAKE_SOURCE_SELECT_BIT]) begin
      wake_edge = psel_sync_r[2] && !psel_sync_r[1];
    end else begin
      wake_edge = intf_r[`IF_SEPDATA_BIT] && dio_sync_r[2] && !dio_sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (main_r[`MAIN_CAL_HI:`MAIN_CAL_LO])
      `CAL_EVERY:    do_cal = 1'b1;
      `CAL_EVERY16:  do_cal = (seq_count_r[3:0] == 4'h0);
      `CAL_EVERY256: do_cal = (seq_count_r == 8'h00);
      default:       do_cal = 1'b0;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEQ_OFF: begin
        if (seqpd_cmd) state_nxt = SEQ_ARMED;
      end
      SEQ_ARMED: begin
        if (wake_edge) state_nxt = do_cal ? CALIBRATION_INTERVAL : SEQ_SETTLE;
      end
      CALIBRATION_INTERVAL: begin
        if (cal_done && !cal_start) state_nxt = SEQ_SETTLE;
      end
      SEQ_SETTLE: begin
        if (wait_cnt_r == 16'h0000 && step_cnt_r == 8'h00) state_nxt = SEQ_CS_CHECK;
      end
      SEQ_CS_CHECK: begin
        if (carrier_r) begin
          state_nxt = SEQ_RX_ON;
        end else if (wait_cnt_r == 16'h0000 && step_cnt_r == 8'h00) begin
          state_nxt = SEQ_ARMED;
        end
      end
      SEQ_RX_ON: begin
        if (seqpd_cmd) state_nxt = SEQ_ARMED;
      end
      default: state_nxt = SEQ_OFF;
    endcase
    if (!seq_mode) state_nxt = SEQ_OFF;
  end

  // State, step counters and the sequence count that paces calibration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= SEQ_OFF;
      wait_cnt_r  <= 16'h0000;
      step_cnt_r  <= 8'h00;
      seq_count_r <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_nxt == SEQ_SETTLE && state_r != SEQ_SETTLE) begin
        wait_cnt_r <= 16'(RX_STEP_CYC - 1);
        step_cnt_r <= {5'h00, seq_cfg_r[`SEQ_RXW_HI:`SEQ_RXW_LO]};
      end else if (state_nxt == SEQ_CS_CHECK && state_r != SEQ_CS_CHECK) begin
        wait_cnt_r <= 16'(CS_STEP_CYC - 1);
        step_cnt_r <= {4'h0, seq_cfg_r[`SEQ_CSW_HI:`SEQ_CSW_LO]};
      end else if (wait_cnt_r != 16'h0000) begin
        wait_cnt_r <= wait_cnt_r - 16'h0001;
      end else if (step_cnt_r != 8'h00) begin
        step_cnt_r <= step_cnt_r - 8'h01;
        wait_cnt_r <= 16'(((state_r == SEQ_SETTLE) ? RX_STEP_CYC : CS_STEP_CYC) - 1);
      end
      if (state_r == SEQ_ARMED && state_nxt != SEQ_ARMED) begin
        seq_count_r <= seq_count_r + 8'h01;
      end
    end
  end

  // Sequencer outputs; outside sequencing mode the receiver is left on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_enable    <= 1'b0;
      cal_start    <= 1'b0;
      powered_down <= 1'b1;
    end else if (clk_en) begin
      rx_enable    <= (state_nxt == SEQ_SETTLE) || (state_nxt == SEQ_CS_CHECK) ||
                      (state_nxt == SEQ_RX_ON) || (state_nxt == SEQ_OFF);
      cal_start    <= (state_r == SEQ_ARMED) && (state_nxt == CALIBRATION_INTERVAL);
      powered_down <= (state_nxt == SEQ_ARMED) || (state_nxt == CALIBRATION_INTERVAL);
    end
  end

  // ----------------------------------------------------------------
  // Sample clock and frequency offsets
  // ----------------------------------------------------------------
  // The divider register holds clock cycles per sample, one eighth of a baud period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r     <= 16'h0000;
      sample_tick_r <= 1'b0;
      sample_clk_r  <= 1'b0;
    end else if (clk_en) begin
      sample_tick_r <= (div_cnt_r == 16'h0000);
      if (div_cnt_r == 16'h0000) begin
        div_cnt_r    <= sample_div_r - 16'h0001;
        sample_clk_r <= 1'b1;
      end else begin
        div_cnt_r    <= div_cnt_r - 16'h0001;
        sample_clk_r <= (div_cnt_r > {1'b0, sample_div_r[15:1]});
      end
    end
  end

  // A first-order low-pass per sample; shift 3 at eight samples per baud
  // puts the corner near 0.17 baud, not the 0.6 baud the document asks. The average keeps four more bits and
  // reports twice the instantaneous scale.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inst_r    <= 8'h00;
      avg_acc_r <= 12'h000;
      avg_r     <= 8'h00;
    end else if (clk_en && sample_tick_r) begin
      inst_r <= inst_r + 8'(($signed(demod_frequency_word) - $signed(inst_r)) >>> 3);
      avg_acc_r <= avg_acc_r + 12'(($signed({{4{inst_r[7]}}, inst_r, 4'h0})
                   - $signed(avg_acc_r)) >>> 4);
      if (!intf_r[`IF_OOK_BIT]) begin
        avg_r <= {avg_acc_r[10:4], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // The data pin is only listened to here, so its driver stays off.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_pin     <= 1'b0;
      data_io_pin_o  <= 1'b0;
      data_io_pin_oe <= 1'b0;
      max_gain       <= 5'h00;
    end else if (clk_en) begin
      case (pin_sel_r)
        `PINSEL_CARRIER:   status_pin <= carrier_r;
        `PINSEL_SAMPLECLK: status_pin <= sample_clk_r;
        default:           status_pin <= 1'b0;
      endcase
      data_io_pin_o  <= 1'b0;
      data_io_pin_oe <= 1'b0;
      max_gain       <= gain_three_r;
    end
  end

endmodule

//--- verification/rf_front_end_model.sv
// Behavioural radio front end that answers calibration requests and feeds the demodulator.
`timescale 1ns/1ps
module rf_front_end_model #(
  parameter int CAL_CYC = 6
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cal_start,
  output logic            cal_done,
  output logic [7:0]      demod_frequency_word
);
  int cnt_r;

  // Calibration finishes a fixed time after each start and then holds done as a level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= 0;
      cal_done <= 1'b0;
    end else if (cal_start) begin
      cnt_r    <= CAL_CYC;
      cal_done <= 1'b0;
    end else if (cnt_r != 0) begin
      cnt_r    <= cnt_r - 1;
      cal_done <= (cnt_r == 1);
    end
  end

  // A steady negative offset keeps the sign of both readbacks predictable.
  assign demod_frequency_word = 8'hF0;
endmodule

//--- verification/rx_wakeup_carrier_sense_sva.sv
// Port-level checker for the receiver wake block, bound to its top module.
`timescale 1ns/1ps
`include "rx_wakeup_regs.svh"
module rx_wakeup_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        data_io_pin_oe,
  input wire logic        rx_enable,
  input wire logic        cal_start,
  input wire logic        powered_down
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Sequencer outputs and data pin: a calibration start is a single pulse, power states never overlap, and the pin is never driven.
  property p_cal_pulse; cal_start |=> !cal_start; endproperty
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("calibration start held longer than one cycle");
  property p_pd_rx; powered_down |-> !rx_enable; endproperty
  a_pd_rx: assert property (p_pd_rx)
    else $error("receiver enabled while powered down");
  property p_wake_rx; $fell(powered_down) |-> rx_enable; endproperty
  a_wake_rx: assert property (p_wake_rx)
    else $error("left power-down without enabling the receiver");
  property p_pin_in; !data_io_pin_oe; endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("data pin driven while used as wake input");

  // Bus answers: write and read responses stand until taken, and read data arrives one cycle after the address.
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before it was taken");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data changed before it was taken");
  property p_rlat; clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat)
    else $error("read answer not one cycle after the address");
  property p_errz; s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_errz: assert property (p_errz)
    else $error("refused read returned nonzero data");

  cover property (cal_start);
  cover property ($fell(powered_down));
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind rx_wakeup_carrier_sense rx_wakeup_sva u_sva (.aclk, .aresetn, .clk_en, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rresp, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .data_io_pin_oe, .rx_enable, .cal_start, .powered_down);

//--- verification/rx_wakeup_carrier_sense_tb.sv
// Self-checking testbench for the receiver wake block.
`timescale 1ns/1ps
`include "rx_wakeup_regs.svh"
module rx_wakeup_carrier_sense_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        wake_select_pin = 1'b1, data_io_pin_i = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rssi_value = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd_d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cal_done, status_pin, rx_enable, cal_start, powered_down;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  demod_frequency_word;
  logic [4:0]  max_gain;
  int          errors = 0, num_checks = 0, cyc = 0, cal_pulses = 0;

  // Short wait steps keep the sequencer delays to a few cycles.
  rx_wakeup_carrier_sense #(.RX_STEP_CYC(4), .CS_STEP_CYC(4)) dut (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rssi_value,
    .demod_frequency_word, .cal_done, .wake_select_pin, .data_io_pin_i, .data_io_pin_o(),
    .data_io_pin_oe(), .status_pin, .rx_enable, .cal_start, .powered_down, .max_gain);
  rf_front_end_model fe (.aclk, .aresetn, .cal_start, .cal_done, .demod_frequency_word);

  // Clock, hang guard and a sticky record of calibration pulses.
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cal_start === 1'b1) cal_pulses++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus master: both write channels offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Waits a bounded time for rx_enable (0), cal_start (1) or powered_down (2) to reach v.
  task automatic wait_for(input logic v, input int which);
    logic s;
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      s = (which == 0) ? rx_enable : (which == 1) ? cal_start : powered_down;
      if (s === v) break;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask

  task automatic t_regs;
    rd(`OFS_SAMPLE_DIV);
    chk(rd_d, {16'h0, `SAMPLE_DIV_RST});
    wr(`OFS_GAIN_THREE, 32'h12);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY});
    @(posedge aclk);
    chk({27'h0, max_gain}, 32'h12);
    rd(8'h28);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
  endtask

  // Threshold sits at level plus eight; the set-mode bit forces the flag off.
  task automatic t_carrier(input logic [31:0] lvl, input logic [7:0] rssi, input logic exp);
    wr(`OFS_GAIN_FOUR, lvl);
    wr(`OFS_PIN_SELECT, {28'h0, `PINSEL_CARRIER});
    rssi_value <= rssi;
    repeat (4) @(posedge aclk);
    rd(`OFS_STATUS);
    chk({31'h0, rd_d[`STAT_CARRIER_BIT]}, {31'h0, exp});
    chk({31'h0, status_pin}, {31'h0, exp});
  endtask

  task automatic t_sample;
    int rises = 0;
    logic last = 1'b0;
    wr(`OFS_SAMPLE_DIV, 32'h4);
    wr(`OFS_PIN_SELECT, {28'h0, `PINSEL_SAMPLECLK});
    repeat (64) begin
      @(posedge aclk);
      if (status_pin === 1'b1 && !last) rises++;
      last = status_pin;
    end
    chk({31'h0, rises >= 4 && rises <= 16}, 32'h1);
    while (status_pin !== 1'b1) @(posedge aclk);
    rd(`OFS_INST_FREQUENCY_WORD);
    chk({31'h0, rd_d[7]}, 32'h1);
    rd(`OFS_AVG_FREQUENCY_WORD);
    chk({31'h0, rd_d[7]}, 32'h1);
  endtask

  task automatic t_arm(input logic [31:0] seq_v, input logic [31:0] if_v, input logic [31:0] m);
    wr(`OFS_INTERFACE, if_v);
    wr(`OFS_SEQUENCING, seq_v);
    wr(`OFS_MAIN, {30'h0, `PDMODE_SEQ});
    wr(`OFS_MAIN, m);
    repeat (2) @(posedge aclk);
    chk({31'h0, powered_down}, 32'h1);
  endtask

  task automatic t_edge(input logic use_data, input logic carrier, input logic exp_cal);
    int c0;
    rssi_value <= carrier ? 8'h20 : 8'h00;
    c0 = cal_pulses;
    if (use_data) data_io_pin_i <= 1'b0;
    else wake_select_pin <= 1'b0;
    wait_for(1'b1, 0);
    chk({31'h0, cal_pulses != c0}, {31'h0, exp_cal});
    if (carrier) begin
      repeat (20) @(posedge aclk);
      chk({31'h0, rx_enable}, 32'h1);
    end else begin
      wait_for(1'b1, 2);
    end
    data_io_pin_i <= 1'b1;
    wake_select_pin <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset, registers, carrier, readbacks, then wake-up sequences.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    // The last level leaves the set-mode bit clear for the wake-up runs.
    t_carrier(32'h25, 8'h0E, 1'b0);
    t_carrier(32'h05, 8'h0D, 1'b0);
    t_carrier(32'h05, 8'h0E, 1'b1);
    t_sample;
    t_arm(32'h01, 32'h0, 32'h17);
    t_edge(1'b0, 1'b0, 1'b1);
    t_edge(1'b0, 1'b0, 1'b0);
    t_arm(32'h01, 32'h0, 32'h37);
    t_edge(1'b0, 1'b0, 1'b0);
    t_arm(32'h00, 32'h1, 32'h07);
    t_edge(1'b1, 1'b0, 1'b1);
    t_edge(1'b1, 1'b1, 1'b1);
    tally_and_finish;
  end
endmodule
